// ==== hdl/pwr_ctl_pkg.sv ====
// constants, field layouts and types of the stop-wake and supply-monitor
// block; assumes a single 20 MHz system clock
package pwr_ctl_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS    = 50;
    localparam int VD_SETTLE_NS     = 20000;
    localparam int VD_SETTLE_CYC    =
        (VD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_DELAY_NS     = 2500000;
    localparam int POR_DELAY_CYC    =
        (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W          = 16;

    // register addresses on the core register port
    localparam logic [7:0] VDC_ADDR = 8'h0C;
    localparam logic [7:0] SRC_ADDR = 8'h0F;

    // voltage_detect_control fields
    localparam int VDC_EN_BIT       = 0;
    localparam int VDC_LV_BIT       = 1;
    localparam int VDC_HV_BIT       = 2;
    localparam logic [7:0] VDC_RESET = 8'h00;

    // stop_recovery_control fields
    localparam int SRC_SEL_LO       = 2;
    localparam int SRC_DELAY_BIT    = 5;
    localparam int SRC_LEVEL_BIT    = 6;
    localparam int SRC_WARM_BIT     = 7;
    localparam logic [7:0] SRC_RESET = 8'h20;

    // recovery source codes
    typedef enum logic [2:0] {
        WSRC_RESET_ONLY = 3'b000,
        WSRC_RESERVED   = 3'b001,
        WSRC_PIN_A      = 3'b010,
        WSRC_PIN_B      = 3'b011,
        WSRC_PIN_C      = 3'b100,
        WSRC_PIN_D      = 3'b101,
        WSRC_NOR_LOW4   = 3'b110,
        WSRC_NOR_ALL8   = 3'b111
    } wake_src_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_STOP  = 2'b01,
        ST_DELAY = 2'b10
    } run_state_t;

endpackage : pwr_ctl_pkg

// ==== hdl/wake_select.sv ====
// combinational wake-condition selector
// assumes port 2 direction bits are 1 for output
`timescale 1ns/1ps
`default_nettype none
module wake_select
    import pwr_ctl_pkg::*;
(
    // configuration
    input  wire logic [2:0] src_sel,
    input  wire logic       level_hi,
    // pins
    input  wire logic [2:0] wake_pins,
    input  wire logic [7:0] port2_in,
    input  wire logic [7:0] port2_dir_out,
    // result
    output logic            wake
);
    logic [7:0] p2_eff;
    logic       src_lvl;
    logic       src_ok;

    // output bits read as low so only the input bits decide the nor
    assign p2_eff = port2_in & ~port2_dir_out;

    always_comb begin
        src_lvl = 1'b0;
        src_ok  = 1'b1;
        case (wake_src_t'(src_sel))
            WSRC_PIN_A:    src_lvl = wake_pins[0];
            WSRC_PIN_B:    src_lvl = wake_pins[1];
            WSRC_PIN_C:    src_lvl = wake_pins[2];
            WSRC_PIN_D:    src_lvl = port2_in[7];
            WSRC_NOR_LOW4: src_lvl = ~|p2_eff[3:0];
            WSRC_NOR_ALL8: src_lvl = ~|p2_eff;
            default:       src_ok  = 1'b0;
        endcase
    end

    assign wake = src_ok && (src_lvl == level_hi);

endmodule : wake_select
`default_nettype wire

// ==== hdl/settle_timer.sv ====
// restartable cycle counter that flags when a fixed count has elapsed
// assumes clear and run come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module settle_timer
    import pwr_ctl_pkg::*;
#(
    parameter int WIDTH  = TIMER_W,
    parameter int CYCLES = VD_SETTLE_CYC
) (
    // clock, reset and enable
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // control
    input  wire logic clear,
    input  wire logic run,
    // status
    output logic      done
);
    localparam logic [WIDTH-1:0] LIMIT = WIDTH'(CYCLES);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } tmr_t;

    tmr_t q;
    tmr_t d;

    assign done = (q.cnt == LIMIT);

    always_comb begin
        d = q;
        if (clear) begin
            d.cnt = '0;
        end else if (run && !done) begin
            d.cnt = q.cnt + WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

endmodule : settle_timer
`default_nettype wire

// ==== hdl/stop_wake_and_voltage_monitor.sv ====
// stop-mode wake control and supply voltage monitor
// assumes core register port, wake pins and comparator levels are all
// synchronous to MCLK
//
// Notes on behaviour
// - three-bit field picks wake source
// - codes 110/111 wake on port 2 nor
// - port 2 outputs excluded from nor
// - delay bit 0 skips power-on delay
// - level bit picks high or low wake
// - warm flag set only by stop recovery
// - enable bit starts supply monitoring
// - flags invalid for 20 us after enable
// - high flag while supply above threshold
// - low flag while supply below threshold
// - upper bits reserved, writes ignored
// - low flag raises low-voltage interrupt
// - interrupt latched until cleared or reset
// - interrupt serviced only when mask set
// - monitoring off in stop mode
`timescale 1ns/1ps
`default_nettype none
module stop_wake_and_voltage_monitor
    import pwr_ctl_pkg::*;
#(
    parameter int POR_DELAY_CYCLES = POR_DELAY_CYC,
    parameter int VD_SETTLE_CYCLES = VD_SETTLE_CYC
) (
    // clock, reset, enable
    input  wire logic       MCLK,
    input  wire logic       RESETN,
    input  wire logic       CLK_EN,
    // core register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RD_DATA,
    // core stop request and run status
    input  wire logic       STOP_REQ,
    output logic            CLK_RUN,
    output logic            CORE_RUN,
    output logic            WARM_START,
    // wake pins
    input  wire logic [2:0] WAKE_PINS,
    input  wire logic [7:0] PORT2_IN,
    input  wire logic [7:0] PORT2_DIR_OUT,
    // supply comparators
    input  wire logic       VCC_ABOVE_HIGH,
    input  wire logic       VCC_BELOW_LOW,
    output logic            VD_ENABLE,
    // interrupt logic
    input  wire logic       LV_IRQ_CLR,
    input  wire logic       LV_IRQ_MASK,
    output logic            LV_IRQ_PENDING,
    output logic            LV_IRQ_SERVICE
);

    typedef struct packed {
        run_state_t st;
        logic       warm;
        logic       level;
        logic       delay;
        logic [2:0] src;
        logic       vd_en;
        logic       hv;
        logic       lv;
        logic       irq;
        logic [7:0] rd;
    } ctl_t;

    ctl_t q;
    ctl_t d;

    logic wake;
    logic vd_active;
    logic vd_settled;
    logic por_done;

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] base);
        addr_hit = (a == base);
    endfunction : addr_hit

    wake_select u_wake (
        .src_sel       (q.src),
        .level_hi      (q.level),
        .wake_pins     (WAKE_PINS),
        .port2_in      (PORT2_IN),
        .port2_dir_out (PORT2_DIR_OUT),
        .wake          (wake)
    );

    // monitor only runs while the core is running
    assign vd_active = q.vd_en && (q.st == ST_RUN);

    settle_timer #(
        .WIDTH  (TIMER_W),
        .CYCLES (VD_SETTLE_CYCLES)
    ) u_vd_settle (
        .clk   (MCLK),
        .rst_n (RESETN),
        .ce    (CLK_EN),
        .clear (!vd_active),
        .run   (vd_active),
        .done  (vd_settled)
    );

    settle_timer #(
        .WIDTH  (TIMER_W),
        .CYCLES (POR_DELAY_CYCLES)
    ) u_por_delay (
        .clk   (MCLK),
        .rst_n (RESETN),
        .ce    (CLK_EN),
        .clear (q.st != ST_DELAY),
        .run   (q.st == ST_DELAY),
        .done  (por_done)
    );

    always_comb begin
        d = q;

        // stop sequencing
        case (q.st)
            ST_RUN: begin
                if (STOP_REQ) begin
                    d.st = ST_STOP;
                end
            end
            ST_STOP: begin
                if (wake) begin
                    d.warm = 1'b1;
                    if (q.delay) begin
                        d.st = ST_DELAY;
                    end else begin
                        d.st = ST_RUN;
                    end
                end
            end
            ST_DELAY: begin
                if (por_done) begin
                    d.st = ST_RUN;
                end
            end
            default: begin
                d.st = ST_RUN;
            end
        endcase

        // register writes; reserved bits are simply not stored
        if (REG_WR && addr_hit(REG_ADDR, VDC_ADDR)) begin
            d.vd_en = REG_WDATA[VDC_EN_BIT];
        end
        if (REG_WR && addr_hit(REG_ADDR, SRC_ADDR)) begin
            d.level = REG_WDATA[SRC_LEVEL_BIT];
            d.delay = REG_WDATA[SRC_DELAY_BIT];
            d.src   = REG_WDATA[SRC_SEL_LO +: 3];
        end

        // flags read as zero until the comparators have settled
        d.hv = vd_active && vd_settled && VCC_ABOVE_HIGH;
        d.lv = vd_active && vd_settled && VCC_BELOW_LOW;

        // latched request, a new event wins over a clear
        d.irq = (q.irq && !LV_IRQ_CLR) || d.lv;

        // registered read data
        if (addr_hit(REG_ADDR, VDC_ADDR)) begin
            d.rd = {5'h00, q.hv, q.lv, q.vd_en};
        end else if (addr_hit(REG_ADDR, SRC_ADDR)) begin
            d.rd = {q.warm, q.level, q.delay, q.src, 2'b00};
        end else begin
            d.rd = 8'h00;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            q.st    <= ST_RUN;
            q.warm  <= SRC_RESET[SRC_WARM_BIT];
            q.level <= SRC_RESET[SRC_LEVEL_BIT];
            q.delay <= SRC_RESET[SRC_DELAY_BIT];
            q.src   <= SRC_RESET[SRC_SEL_LO +: 3];
            q.vd_en <= VDC_RESET[VDC_EN_BIT];
            q.hv    <= VDC_RESET[VDC_HV_BIT];
            q.lv    <= VDC_RESET[VDC_LV_BIT];
            q.irq   <= 1'b0;
            q.rd    <= 8'h00;
        end else if (CLK_EN) begin
            q <= d;
        end
    end

    assign REG_RD_DATA    = q.rd;
    assign CLK_RUN        = (q.st != ST_STOP);
    assign CORE_RUN       = (q.st == ST_RUN);
    assign WARM_START     = q.warm;
    assign VD_ENABLE      = vd_active;
    assign LV_IRQ_PENDING = q.irq;
    assign LV_IRQ_SERVICE = q.irq && LV_IRQ_MASK;

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    property p_reset_src_no_wake;
        (CLK_EN && q.st == ST_STOP && q.src[2:1] == 2'b00)
            |=> (q.st == ST_STOP);
    endproperty
    a_reset_src_no_wake: assert property (p_reset_src_no_wake)
        else $error("stop left with reset-only source");

    property p_fast_wake;
        (CLK_EN && q.st == ST_STOP && wake && !q.delay)
            |=> (CORE_RUN && CLK_RUN);
    endproperty
    a_fast_wake: assert property (p_fast_wake)
        else $error("fast wake did not resume execution");

    property p_delayed_wake;
        (CLK_EN && q.st == ST_STOP && wake && q.delay)
            |=> (CLK_RUN && !CORE_RUN);
    endproperty
    a_delayed_wake: assert property (p_delayed_wake)
        else $error("delayed wake skipped the power-on delay");

    property p_warm_set;
        (CLK_EN && q.st == ST_STOP && wake) |=> WARM_START;
    endproperty
    a_warm_set: assert property (p_warm_set)
        else $error("warm flag not set on recovery");

    property p_vd_write;
        (CLK_EN && REG_WR && REG_ADDR == VDC_ADDR)
            |=> (q.vd_en == $past(REG_WDATA[VDC_EN_BIT]));
    endproperty
    a_vd_write: assert property (p_vd_write)
        else $error("enable bit not written");

    property p_flags_gated;
        (CLK_EN && !vd_settled) |=> (!q.lv && !q.hv);
    endproperty
    a_flags_gated: assert property (p_flags_gated)
        else $error("flag valid before settle time");

    property p_irq_raise;
        (CLK_EN && vd_active && vd_settled && VCC_BELOW_LOW)
            |=> LV_IRQ_PENDING;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("low voltage did not raise request");

    property p_irq_hold;
        (LV_IRQ_PENDING && !LV_IRQ_CLR) |=> LV_IRQ_PENDING;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("request dropped without a clear");

    property p_irq_mask;
        (!LV_IRQ_MASK || !LV_IRQ_PENDING) |-> !LV_IRQ_SERVICE;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("request serviced while masked");

    property p_stop_monitor_off;
        (q.st == ST_STOP) |-> (!VD_ENABLE ##1 !q.lv);
    endproperty
    a_stop_monitor_off: assert property (p_stop_monitor_off)
        else $error("monitor active in stop mode");

    property p_pin_a_wake;
        (CLK_EN && q.st == ST_STOP && q.src == WSRC_PIN_A
            && WAKE_PINS[0] == q.level) |=> CLK_RUN;
    endproperty
    a_pin_a_wake: assert property (p_pin_a_wake)
        else $error("pin a level did not wake");

    property p_nor_masked_wake;
        (CLK_EN && q.st == ST_STOP && q.src == WSRC_NOR_LOW4 && q.level
            && (PORT2_IN[3:0] & ~PORT2_DIR_OUT[3:0]) == 4'h0) |=> CLK_RUN;
    endproperty
    a_nor_masked_wake: assert property (p_nor_masked_wake)
        else $error("output bits blocked the port 2 wake");

    property p_nor_all8_wake;
        (CLK_EN && q.st == ST_STOP && q.src == WSRC_NOR_ALL8
            && PORT2_DIR_OUT == 8'h00 && (~|PORT2_IN) == q.level)
            |=> CLK_RUN;
    endproperty
    a_nor_all8_wake: assert property (p_nor_all8_wake)
        else $error("port 2 nor did not wake");

    property p_rd_reserved;
        (CLK_EN && REG_ADDR == VDC_ADDR) |=> (REG_RD_DATA[7:3] == 5'h00);
    endproperty
    a_rd_reserved: assert property (p_rd_reserved)
        else $error("reserved monitor bits read nonzero");

    property p_warm_hold;
        WARM_START |=> WARM_START;
    endproperty
    a_warm_hold: assert property (p_warm_hold)
        else $error("warm flag cleared without reset");

endmodule : stop_wake_and_voltage_monitor
`default_nettype wire

// ==== verification/supply_model.sv ====
// behavioural supply comparators facing the voltage monitor
// assumes the bench sets the supply condition just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module supply_model (
    // clock and enable
    input  wire logic       clk,
    input  wire logic       enable,
    // supply condition: 0 normal, 1 low, 2 high
    input  wire logic [1:0] supply,
    // comparator levels
    output logic            above_high,
    output logic            below_low
);
    logic junk_q = 1'h0;

    always @(posedge clk) begin
        junk_q <= ~junk_q;
    end

    // powered-down comparators give no valid level
    always_comb begin
        if (enable) begin
            above_high = (supply == 2'h2);
            below_low  = (supply == 2'h1);
        end else begin
            above_high = junk_q;
            below_low  = ~junk_q;
        end
    end
endmodule : supply_model
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the stop-wake and supply-monitor block
// assumes the supply model drives the comparator levels
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; \
    if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module testbench
    import pwr_ctl_pkg::*;
;
    localparam int POR = 20;
    localparam int SET = 8;
    logic       MCLK, RESETN, STOP_REQ, REG_WR, LV_IRQ_CLR, LV_IRQ_MASK;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RD_DATA, PORT2_IN, PORT2_DIR_OUT;
    logic [2:0] WAKE_PINS;
    logic [1:0] supply;
    logic       CLK_RUN, CORE_RUN, WARM_START, VD_ENABLE, VCC_ABOVE_HIGH;
    logic       VCC_BELOW_LOW, LV_IRQ_PENDING, LV_IRQ_SERVICE, CLK_EN;
    int         n_mismatch = 0;
    int         n_compared = 0;
    int         n;

    stop_wake_and_voltage_monitor #(
        .POR_DELAY_CYCLES(POR),
        .VD_SETTLE_CYCLES(SET)
    ) uut (
        .MCLK(MCLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
        .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
        .REG_RD_DATA(REG_RD_DATA), .STOP_REQ(STOP_REQ), .CLK_RUN(CLK_RUN),
        .CORE_RUN(CORE_RUN), .WARM_START(WARM_START), .WAKE_PINS(WAKE_PINS),
        .PORT2_IN(PORT2_IN), .PORT2_DIR_OUT(PORT2_DIR_OUT),
        .VCC_ABOVE_HIGH(VCC_ABOVE_HIGH), .VCC_BELOW_LOW(VCC_BELOW_LOW),
        .VD_ENABLE(VD_ENABLE), .LV_IRQ_CLR(LV_IRQ_CLR),
        .LV_IRQ_MASK(LV_IRQ_MASK), .LV_IRQ_PENDING(LV_IRQ_PENDING),
        .LV_IRQ_SERVICE(LV_IRQ_SERVICE)
    );

    supply_model sm (
        .clk(MCLK), .enable(VD_ENABLE), .supply(supply),
        .above_high(VCC_ABOVE_HIGH), .below_low(VCC_BELOW_LOW)
    );

    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic tick(input int k);
        repeat (k) @(posedge MCLK);
        #2;
    endtask : tick

    task automatic tmo();
        if (n >= 100) begin
            n_mismatch++;
            summarize();
        end
    endtask : tmo

    task automatic do_reset();
        RESETN = 1'b0;
        tick(5);
        RESETN = 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        tick(1);
        REG_WR = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        REG_ADDR = a;
        tick(1);
        `CHK("read data", e, REG_RD_DATA)
    endtask : rd

    task automatic pins(input logic [10:0] p);
        {PORT2_IN, WAKE_PINS} = p;
    endtask : pins

    task automatic stop();
        STOP_REQ = 1'b1;
        tick(1);
        STOP_REQ = 1'b0;
        `CHK("clock run", 1'b0, CLK_RUN)
    endtask : stop

    task automatic t_regs();
        `CHK("warm flag", 1'b0, WARM_START)
        `CHK("monitor on", 1'b0, VD_ENABLE)
        `CHK("pending", 1'b0, LV_IRQ_PENDING)
        rd(SRC_ADDR, SRC_RESET);
        rd(VDC_ADDR, VDC_RESET);
        rd(8'h33, 8'h00);
        wr(VDC_ADDR, 8'hFE);
        rd(VDC_ADDR, 8'h00);
        wr(SRC_ADDR, 8'hFF);
        rd(SRC_ADDR, 8'h7C);
    endtask : t_regs

    task automatic t_freeze();
        CLK_EN = 1'b0;
        wr(VDC_ADDR, 8'h01);
        CLK_EN = 1'b1;
        tick(1);
        `CHK("monitor on", 1'b0, VD_ENABLE)
    endtask : t_freeze

    task automatic t_mon();
        LV_IRQ_MASK = 1'b1;
        supply = 2'h1;
        wr(VDC_ADDR, 8'h01);
        `CHK("monitor on", 1'b1, VD_ENABLE)
        n = 0;
        do begin
            tick(1);
            n++;
        end while (LV_IRQ_PENDING !== 1'b1 && n < 100);
        tmo();
        `CHK("settle", SET + 1, n)
        `CHK("service", 1'b1, LV_IRQ_SERVICE)
        rd(VDC_ADDR, 8'h03);
        LV_IRQ_MASK = 1'b0;
        LV_IRQ_CLR = 1'b1;
        tick(1);
        LV_IRQ_CLR = 1'b0;
        `CHK("service", 1'b0, LV_IRQ_SERVICE)
        `CHK("pending", 1'b1, LV_IRQ_PENDING)
        supply = 2'h0;
        tick(2);
        `CHK("pending", 1'b1, LV_IRQ_PENDING)
        LV_IRQ_CLR = 1'b1;
        tick(1);
        LV_IRQ_CLR = 1'b0;
        `CHK("pending", 1'b0, LV_IRQ_PENDING)
        supply = 2'h2;
        tick(2);
        rd(VDC_ADDR, 8'h05);
        wr(SRC_ADDR, 8'h08);
        pins(11'h7FF);
        stop();
        `CHK("monitor on", 1'b0, VD_ENABLE)
        pins(11'h7FE);
        tick(5);
        pins(11'h7FF);
        rd(VDC_ADDR, 8'h01);
        wr(VDC_ADDR, 8'h00);
        rd(VDC_ADDR, 8'h00);
    endtask : t_mon

    task automatic wake(input logic [2:0] s, input logic l,
                        input logic [10:0] idle, input logic [10:0] act,
                        input logic [7:0] dir, input logic e);
        wr(SRC_ADDR, {1'b0, l, 1'b0, s, 2'b00});
        pins(idle);
        PORT2_DIR_OUT = 8'h00;
        stop();
        tick(3);
        `CHK("core run", 1'b0, CORE_RUN)
        pins(act);
        PORT2_DIR_OUT = dir;
        tick(1);
        `CHK("core run", e, CORE_RUN)
        tick(4);
        pins(idle);
        PORT2_DIR_OUT = 8'h00;
        if (e) `CHK("warm flag", 1'b1, WARM_START)
    endtask : wake

    task automatic t_delay();
        wr(SRC_ADDR, 8'h28);
        pins(11'h7FF);
        stop();
        pins(11'h7FE);
        tick(1);
        `CHK("clock run", 1'b1, CLK_RUN)
        `CHK("core run", 1'b0, CORE_RUN)
        n = 0;
        while (CORE_RUN !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        tmo();
        `CHK("delay", POR + 1, n)
        pins(11'h7FF);
    endtask : t_delay

    initial begin
        STOP_REQ = 1'b0;
        CLK_EN = 1'b1;
        REG_WR = 1'b0;
        LV_IRQ_CLR = 1'b0;
        LV_IRQ_MASK = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        PORT2_DIR_OUT = 8'h00;
        supply = 2'h0;
        pins(11'h7FF);
        do_reset();
        t_regs();
        t_freeze();
        t_mon();
        wake(3'h2, 1'b0, 11'h7FF, 11'h7FE, 8'h00, 1'b1);
        wake(3'h3, 1'b1, 11'h000, 11'h002, 8'h00, 1'b1);
        wake(3'h4, 1'b0, 11'h7FF, 11'h7FB, 8'h00, 1'b1);
        wake(3'h5, 1'b1, 11'h000, 11'h400, 8'h00, 1'b1);
        wake(3'h6, 1'b0, 11'h400, 11'h440, 8'h00, 1'b1);
        wake(3'h7, 1'b0, 11'h000, 11'h400, 8'h00, 1'b1);
        wake(3'h6, 1'b1, 11'h078, 11'h078, 8'h0F, 1'b1);
        t_delay();
        wake(3'h1, 1'b0, 11'h7FF, 11'h000, 8'h00, 1'b0);
        wake(3'h0, 1'b0, 11'h7FF, 11'h000, 8'h00, 1'b0);
        do_reset();
        `CHK("warm flag", 1'b0, WARM_START)
        `CHK("core run", 1'b1, CORE_RUN)
        summarize();
    end
endmodule : testbench
`default_nettype wire
